// *** core/wdt_pkg.sv ***
// shared constants for the timebase window watchdog and its controller
package wdt_pkg;
  // =========================================================
  // watchdog register offsets
  localparam logic [7:0] OFF_CSR_FIRST  = 8'h00;
  localparam logic [7:0] OFF_CSR_SECOND = 8'h04;
  localparam logic [7:0] OFF_TIMEBASE   = 8'h08;
  localparam logic [7:0] OFF_EN_STATUS  = 8'h10;
  localparam logic [7:0] OFF_FUNC_CTRL  = 8'h14;
  localparam logic [7:0] OFF_CLOSE_WIN  = 8'h18;
  localparam logic [7:0] OFF_OPEN_WIN   = 8'h1c;
  localparam logic [7:0] OFF_SIG_INIT   = 8'h20;
  localparam logic [7:0] OFF_SIG_RESULT = 8'h24;
  localparam logic [7:0] OFF_DELAY_CNT  = 8'h28;
  // =========================================================
  // field positions
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_STATE    = 2;
  localparam int BIT_RST_STAT = 3;
  localparam int BIT_RESTART  = 1;
  localparam int BIT_WINT     = 2;
  localparam int BIT_PENDING  = 3;
  localparam int BIT_FAIL_LO  = 8;
  localparam int BIT_SEQ_EN   = 0;
  localparam int BIT_DELAY_EN = 1;
  localparam int BIT_FAIL_EN  = 2;
  // =========================================================
  // reset values and limits
  localparam logic [2:0]  FAIL_RESET = 3'h5;
  localparam logic [2:0]  FAIL_MAX   = 3'h7;
  localparam logic [2:0]  FAIL_MIN   = 3'h0;
  localparam logic [31:0] WIN_RESET  = 32'h0000_00ff;
  localparam logic [31:0] TB_MAX     = 32'hffff_ffff;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  // =========================================================
  // controller register offsets (on its AHB-Lite side)
  localparam logic [7:0] OFF_CMD_ADDR  = 8'h00;
  localparam logic [7:0] OFF_CMD_WDATA = 8'h04;
  localparam logic [7:0] OFF_CMD_GO    = 8'h08;
  localparam logic [7:0] OFF_CMD_STAT  = 8'h0c;
  localparam logic [7:0] OFF_CMD_RDATA = 8'h10;
  localparam int BIT_GO    = 0;
  localparam int BIT_WRITE = 1;
  localparam int BIT_BUSY  = 0;
  localparam int BIT_DONE  = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction
endpackage

// *** core/wdt_link_if.sv ***
// axi4-lite link between the watchdog and its controller
`timescale 1ns/1ps
interface wdt_link_if;
  logic        awvalid;
  logic        awready;
  logic [7:0]  awaddr;
  logic        wvalid;
  logic        wready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        bvalid;
  logic        bready;
  logic [1:0]  bresp;
  logic        arvalid;
  logic        arready;
  logic [7:0]  araddr;
  logic        rvalid;
  logic        rready;
  logic [31:0] rdata;
  logic [1:0]  rresp;

  modport device (input awvalid, awaddr, wvalid, wdata, wstrb, bready, arvalid, araddr,
                  rready, output awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp);
  modport controller (output awvalid, awaddr, wvalid, wdata, wstrb, bready, arvalid, araddr,
                      rready, input awready, wready, bvalid, bresp, arready, rvalid, rdata,
                      rresp);
endinterface

// *** core/timebase_window_watchdog.sv ***
// watchdog with free-running timebase, legacy and windowed modes, axi4-lite slave
`timescale 1ns/1ps
module timebase_window_watchdog
  import wdt_pkg::*;
#(
  parameter bit WINDOWED    = 1'b0,
  parameter int WDT_WIDTH   = 8,
  parameter bit ENABLE_ONCE = 1'b0,
  parameter int DELAY_WIDTH = 8
) (
  // clock and resets
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic por_n,
  // link to the controller
  wdt_link_if.device link,
  // system side
  input  wire logic freeze,
  output logic      wdt_reset,
  output logic      wdt_reset_pending,
  output logic      wdt_interrupt,
  output logic      tb_interrupt
);
  // =========================================================
  // bus slave
  logic        bvalid_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  wire         wr_fire = link.awvalid & link.wvalid & ~bvalid_q;
  wire         rd_fire = link.arvalid & ~rvalid_q;
  wire  [7:0]  wa      = link.awaddr;
  wire  [31:0] wd      = link.wdata;
  logic [31:0] rd_val;

  assign link.awready = wr_fire;
  assign link.wready  = wr_fire;
  assign link.bvalid  = bvalid_q;
  assign link.bresp   = RESP_OKAY;
  assign link.arready = rd_fire;
  assign link.rvalid  = rvalid_q;
  assign link.rdata   = rdata_q;
  assign link.rresp   = RESP_OKAY;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
    end else begin
      bvalid_q <= wr_fire | (bvalid_q & ~link.bready);
      rvalid_q <= rd_fire | (rvalid_q & ~link.rready);
      if (rd_fire) rdata_q <= rd_val;
    end
  end

  // =========================================================
  // legacy watchdog
  logic                 en_first;
  logic                 en_second;
  logic                 state_bit;
  logic                 leg_expired;
  logic [WDT_WIDTH-1:0] wdt_cnt;
  wire leg_en     = ~WINDOWED & (en_first | en_second);
  wire wr_first   = wr_fire & ~WINDOWED & hit(wa, OFF_CSR_FIRST);
  wire wr_second  = wr_fire & ~WINDOWED & hit(wa, OFF_CSR_SECOND);
  // enable-once: a running watchdog ignores attempts to clear either enable
  wire leg_locked = leg_expired | (ENABLE_ONCE & leg_en);
  // the counter wraps after 2**WDT_WIDTH cycles
  wire expiry     = leg_en & ~leg_expired & ~freeze & (&wdt_cnt);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_first    <= 1'b0;
      en_second   <= 1'b0;
      state_bit   <= 1'b0;
      leg_expired <= 1'b0;
      wdt_cnt     <= '0;
    end else begin
      if (wr_first && !(leg_locked && !wd[BIT_ENABLE])) en_first <= wd[BIT_ENABLE];
      if (wr_second && !(leg_locked && !wd[BIT_ENABLE])) en_second <= wd[BIT_ENABLE];
      if (expiry && !state_bit) begin
        state_bit <= 1'b1;
      end else if (wr_first && wd[BIT_STATE] && !expiry) begin
        state_bit <= 1'b0;
      end
      if (expiry && state_bit) leg_expired <= 1'b1;
      if (!leg_en || leg_expired) begin
        wdt_cnt <= '0;
      end else if (!freeze) begin
        wdt_cnt <= wdt_cnt + 1'b1;
      end
    end
  end

  // =========================================================
  // windowed watchdog
  logic                   wen;
  logic                   in_open;
  logic                   win_dead;
  logic                   win_reset;
  logic                   wint;
  logic                   pending;
  logic [31:0]            win_cnt;
  logic [31:0]            close_len;
  logic [31:0]            open_len;
  logic [31:0]            sig_init;
  logic [31:0]            sig_result;
  logic [2:0]             func_ctrl;
  logic [2:0]             fail_counter;
  logic [DELAY_WIDTH-1:0] delay_cnt;
  wire wr_es      = wr_fire & WINDOWED & hit(wa, OFF_EN_STATUS);
  wire seq_en     = func_ctrl[BIT_SEQ_EN];
  wire delay_en   = func_ctrl[BIT_DELAY_EN];
  wire fail_en    = func_ctrl[BIT_FAIL_EN];
  wire live       = wen & ~win_dead;
  wire kick       = wr_es & live & (wd[BIT_RESTART] | ~wd[BIT_ENABLE]);
  wire sig_bad    = seq_en & (sig_init != sig_result);
  wire good       = kick & in_open & ~sig_bad;
  wire open_over  = live & in_open & (win_cnt == open_len) & ~kick;
  wire bad        = (kick & ~good) | open_over;
  wire trigger    = bad & ~pending & (~fail_en | (fail_counter == FAIL_MAX));
  wire delay_done = pending & (&delay_cnt);
  wire fire       = (trigger & ~delay_en) | delay_done;
  wire wen_start  = wr_es & wd[BIT_ENABLE] & ~wen & ~win_dead;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wen          <= 1'b0;
      in_open      <= 1'b0;
      win_dead     <= 1'b0;
      win_reset    <= 1'b0;
      wint         <= 1'b0;
      pending      <= 1'b0;
      win_cnt      <= 32'h0;
      close_len    <= WIN_RESET;
      open_len     <= WIN_RESET;
      sig_init     <= 32'h0;
      sig_result   <= 32'h0;
      func_ctrl    <= 3'h0;
      fail_counter <= FAIL_RESET;
      delay_cnt    <= '0;
    end else begin
      if (wr_fire && WINDOWED && !live) begin
        if (hit(wa, OFF_FUNC_CTRL)) func_ctrl <= wd[2:0];
        if (hit(wa, OFF_CLOSE_WIN)) close_len <= wd;
        if (hit(wa, OFF_OPEN_WIN)) open_len <= wd;
      end
      if (wr_fire && WINDOWED && hit(wa, OFF_SIG_INIT)) sig_init <= wd;
      if (wr_fire && WINDOWED && hit(wa, OFF_SIG_RESULT)) sig_result <= wd;
      if (bad) begin
        wint <= 1'b1;
      end else if (wr_es && wd[BIT_WINT]) begin
        wint <= 1'b0;
      end
      if (fail_en && good && fail_counter != FAIL_MIN) fail_counter <= fail_counter - 1'b1;
      if (fail_en && bad && fail_counter != FAIL_MAX) fail_counter <= fail_counter + 1'b1;
      if (trigger && delay_en) pending <= 1'b1;
      delay_cnt <= pending ? delay_cnt + 1'b1 : '0;
      if (fire) begin
        win_reset <= 1'b1;
        win_dead  <= 1'b1;
        wen       <= 1'b0;
        pending   <= 1'b0;
      end else if (wen_start) begin
        wen     <= 1'b1;
        in_open <= 1'b0;
        win_cnt <= 32'h0;
      end else if (good && !wd[BIT_ENABLE] && !ENABLE_ONCE) begin
        wen <= 1'b0;
      end else if (good || open_over) begin
        in_open <= 1'b0;
        win_cnt <= 32'h0;
      end else if (live && !in_open && win_cnt == close_len) begin
        in_open <= 1'b1;
        win_cnt <= 32'h0;
      end else if (live) begin
        win_cnt <= win_cnt + 1'b1;
      end
    end
  end

  // =========================================================
  // timebase and reset cause
  logic [31:0] timebase;
  logic        tb_pulse;
  logic        rst_cause;
  wire leg_start = ~leg_en & ((wr_first | wr_second) & wd[BIT_ENABLE]);
  wire tb_clear  = leg_start | wen_start;
  wire any_reset = WINDOWED ? win_reset : leg_expired;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timebase <= 32'h0;
      tb_pulse <= 1'b0;
    end else begin
      timebase <= tb_clear ? 32'h0 : timebase + 32'h1;
      tb_pulse <= ~tb_clear & (timebase == TB_MAX);
    end
  end

  // reset cause survives the bus reset; only a power-on reset or a write of its status bit clears it
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      rst_cause <= 1'b0;
    end else if (any_reset) begin
      rst_cause <= 1'b1;
    end else if (wr_fire && hit(wa, WINDOWED ? OFF_EN_STATUS : OFF_CSR_FIRST)
                 && wd[BIT_RST_STAT + 1 - 1 + (WINDOWED ? 1 : 0)]) begin
      rst_cause <= 1'b0;
    end
  end

  // =========================================================
  // read map and outputs
  wire [31:0] csr_first = {timebase[31:4], rst_cause, state_bit, 1'b0, leg_en};
  wire [31:0] es_word   = {20'h0, 1'b0, fail_counter, 3'h0, rst_cause, pending, wint,
                           1'b0, wen};
  wire [7:0]  ra        = link.araddr;
  assign rd_val = !WINDOWED ? (hit(ra, OFF_CSR_FIRST) ? csr_first :
                               hit(ra, OFF_TIMEBASE)  ? timebase  : 32'h0) :
                  hit(ra, OFF_EN_STATUS)  ? es_word :
                  hit(ra, OFF_FUNC_CTRL)  ? {29'h0, func_ctrl} :
                  hit(ra, OFF_CLOSE_WIN)  ? close_len :
                  hit(ra, OFF_OPEN_WIN)   ? open_len :
                  hit(ra, OFF_SIG_INIT)   ? sig_init :
                  hit(ra, OFF_SIG_RESULT) ? sig_result :
                  hit(ra, OFF_DELAY_CNT)  ? {{(32 - DELAY_WIDTH){1'b0}}, delay_cnt} : 32'h0;

  assign wdt_reset         = any_reset;
  assign wdt_reset_pending = WINDOWED & pending;
  assign wdt_interrupt     = WINDOWED ? wint : state_bit;
  assign tb_interrupt      = tb_pulse;
endmodule // timebase_window_watchdog

// *** core/wdt_link_controller.sv ***
// ahb-lite programmable axi4-lite master that drives the watchdog link
`timescale 1ns/1ps
module wdt_link_controller
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // link to the watchdog
  wdt_link_if.controller   link
);
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_WADDR = 5'b00010,
    ST_WRESP = 5'b00100,
    ST_RADDR = 5'b01000,
    ST_RDATA = 5'b10000
  } ctrl_state_type;

  // =========================================================
  // ahb-lite slave, zero wait states
  logic        dp_write;
  logic [7:0]  dp_addr;
  logic [7:0]  cmd_addr;
  logic [31:0] cmd_wdata;
  logic [31:0] cmd_rdata;
  logic        done;
  logic        aw_done;
  logic        w_done;
  ctrl_state_type state;
  wire  ap_valid = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire  busy     = state != ST_IDLE;
  wire  go       = dp_write & hit(dp_addr, OFF_CMD_GO) & hwdata[BIT_GO] & ~busy;
  wire  finish   = (state == ST_WRESP & link.bvalid) | (state == ST_RDATA & link.rvalid);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hit(dp_addr, OFF_CMD_ADDR)  ? {24'h0, cmd_addr} :
                     hit(dp_addr, OFF_CMD_WDATA) ? cmd_wdata :
                     hit(dp_addr, OFF_CMD_STAT)  ? {30'h0, done, busy} :
                     hit(dp_addr, OFF_CMD_RDATA) ? cmd_rdata : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write  <= 1'b0;
      dp_addr   <= 8'h0;
      cmd_addr  <= 8'h0;
      cmd_wdata <= 32'h0;
    end else begin
      dp_write <= ap_valid & hwrite;
      if (ap_valid) dp_addr <= haddr;
      // the target address and data are locked while a transfer runs
      if (dp_write && !busy && hit(dp_addr, OFF_CMD_ADDR)) cmd_addr <= hwdata[7:0];
      if (dp_write && !busy && hit(dp_addr, OFF_CMD_WDATA)) cmd_wdata <= hwdata;
    end
  end

  // =========================================================
  // axi4-lite master
  assign link.awvalid = (state == ST_WADDR) & ~aw_done;
  assign link.wvalid  = (state == ST_WADDR) & ~w_done;
  assign link.awaddr  = cmd_addr;
  assign link.wdata   = cmd_wdata;
  assign link.wstrb   = 4'hf;
  assign link.bready  = state == ST_WRESP;
  assign link.arvalid = state == ST_RADDR;
  assign link.araddr  = cmd_addr;
  assign link.rready  = state == ST_RDATA;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ST_IDLE;
      aw_done   <= 1'b0;
      w_done    <= 1'b0;
      done      <= 1'b0;
      cmd_rdata <= 32'h0;
    end else begin
      if (finish) begin
        done <= 1'b1;
      end else if (go) begin
        done <= 1'b0;
      end
      unique case (state)
        ST_IDLE: begin
          aw_done <= 1'b0;
          w_done  <= 1'b0;
          if (go) state <= hwdata[BIT_WRITE] ? ST_WADDR : ST_RADDR;
        end
        ST_WADDR: begin
          if (link.awready) aw_done <= 1'b1;
          if (link.wready) w_done <= 1'b1;
          if ((aw_done | link.awready) & (w_done | link.wready)) state <= ST_WRESP;
        end
        ST_WRESP: begin
          if (link.bvalid) state <= ST_IDLE;
        end
        ST_RADDR: begin
          if (link.arready) state <= ST_RDATA;
        end
        ST_RDATA: begin
          if (link.rvalid) begin
            cmd_rdata <= link.rdata;
            state     <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule // wdt_link_controller

// *** verif/wdt_link_checker.sv ***
// concurrent checks on the legacy watchdog link and its system outputs
`timescale 1ns/1ps
module wdt_link_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // link handshake
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // system side
  input wire logic        freeze,
  input wire logic        wdt_reset,
  input wire logic        wdt_reset_pending,
  input wire logic        wdt_interrupt,
  input wire logic        tb_interrupt
);
  // ==========================================================
  // watchdog outputs
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_reset_sticks: assert property (wdt_reset |=> wdt_reset)
    else $error("watchdog reset dropped without bus reset");
  a_reset_after_irq: assert property ($rose(wdt_reset) |-> $past(wdt_interrupt))
    else $error("watchdog reset without a pending interrupt");
  a_irq_holds: assert property (wdt_interrupt && !(awvalid && awready) |=> wdt_interrupt)
    else $error("interrupt dropped without a write");
  a_freeze_stalls: assert property (freeze [*3] |-> !$rose(wdt_interrupt))
    else $error("interrupt rose while frozen");
  a_tb_pulse_single: assert property (tb_interrupt |=> !tb_interrupt)
    else $error("timebase interrupt longer than one clock");
  a_pending_idle: assert property (!wdt_reset_pending)
    else $error("reset pending raised in legacy mode");
  // ==========================================================
  // link answers
  a_write_answer: assert property (awvalid && awready |=> bvalid)
    else $error("write taken but no response next cycle");
  a_bvalid_holds: assert property (bvalid && !bready |=> bvalid)
    else $error("write response withdrawn early");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read taken but no data next cycle");
  a_rdata_stable: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before it was taken");
endmodule // wdt_link_checker

// *** verif/timebase_window_watchdog_test.sv ***
// self-checking bench: two controller pairs drive a legacy and a windowed watchdog
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module timebase_window_watchdog_test
  import wdt_pkg::*;
;
  localparam logic LEG = 1'b0;
  localparam logic WIN = 1'b1;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        por_n;
  logic        freeze;
  logic        sel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata_l, hrdata_w, q, t;
  logic        hro_l, hro_w, rst_l, pend_l, irq_l, tbi_l, rst_w, pend_w, irq_w, tbi_w;
  int          c;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;
  wire         hready = sel ? hro_w : hro_l;
  wire [31:0]  hrdata = sel ? hrdata_w : hrdata_l;

  wdt_link_if lnk_l ();
  wdt_link_if lnk_w ();

  wdt_link_controller wdt_link_controller_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(!sel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hro_l), .hresp(), .hrdata(hrdata_l), .link(lnk_l.controller));
  wdt_link_controller wdt_link_controller_w_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(sel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hro_w), .hresp(), .hrdata(hrdata_w), .link(lnk_w.controller));
  timebase_window_watchdog #(.WINDOWED(1'b0), .WDT_WIDTH(8)) timebase_window_watchdog_i (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .link(lnk_l.device), .freeze(freeze),
    .wdt_reset(rst_l), .wdt_reset_pending(pend_l), .wdt_interrupt(irq_l),
    .tb_interrupt(tbi_l));
  // windowed instance: freeze only matters to the legacy counter
  timebase_window_watchdog #(.WINDOWED(1'b1), .DELAY_WIDTH(8)) timebase_window_watchdog_w_i (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .link(lnk_w.device), .freeze(1'b0),
    .wdt_reset(rst_w), .wdt_reset_pending(pend_w), .wdt_interrupt(irq_w),
    .tb_interrupt(tbi_w));
  wdt_link_checker wdt_link_checker_i (
    .hclk(hclk), .hresetn(hresetn), .awvalid(lnk_l.awvalid), .awready(lnk_l.awready),
    .bvalid(lnk_l.bvalid), .bready(lnk_l.bready), .arvalid(lnk_l.arvalid),
    .arready(lnk_l.arready), .rvalid(lnk_l.rvalid), .rready(lnk_l.rready),
    .rdata(lnk_l.rdata), .freeze(freeze), .wdt_reset(rst_l), .wdt_reset_pending(pend_l),
    .wdt_interrupt(irq_l), .tb_interrupt(tbi_l));

  // ==========================================================
  // clock, timeout, verdict
  always #5 hclk = ~hclk;

  task automatic conclude();
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  // ==========================================================
  // bus tasks
  task automatic ahb(input logic s, input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] x);
    @(posedge hclk);
    sel <= s;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    x = hrdata;
  endtask

  // one link access through the controller; a poll limit keeps a stuck link visible
  task automatic xfer(input logic s, input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] x);
    logic [31:0] st;
    int n;
    ahb(s, 1'b1, OFF_CMD_ADDR, {24'h0, a}, st);
    ahb(s, 1'b1, OFF_CMD_WDATA, d, st);
    ahb(s, 1'b1, OFF_CMD_GO, {30'h0, w, 1'b1}, st);
    n = 0;
    do begin
      ahb(s, 1'b0, OFF_CMD_STAT, 32'h0, st);
      n++;
    end while (st[BIT_DONE] !== 1'b1 && n < 50);
    // a poll limit that runs out is a failure, not a silent pass
    if (st[BIT_DONE] !== 1'b1) begin
      failures++;
      $display("MISMATCH t=%0t link transfer never finished", $time);
    end
    ahb(s, 1'b0, OFF_CMD_RDATA, 32'h0, x);
  endtask

  task automatic wait_hi(ref logic sig, input int lim, output int n);
    n = 0;
    while (sig !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask

  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    por_n = 1'b0;
    freeze = 1'b0;
    sel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    // legacy: timebase and status word
    xfer(LEG, 1'b0, OFF_CSR_FIRST, 32'h0, q);
    `CHK(q[3:0], 4'h0)
    xfer(LEG, 1'b0, OFF_TIMEBASE, 32'h0, t);
    `CHK((t[31:4] - q[31:4]) < 28'h6, 1'b1)
    xfer(LEG, 1'b0, OFF_TIMEBASE, 32'h0, q);
    `CHK((q - t) inside {[32'h1:32'h50]}, 1'b1)
    // legacy: two expiries lead to reset
    xfer(LEG, 1'b1, OFF_CSR_FIRST, 32'h1, q);
    wait_hi(irq_l, 400, c);
    `CHK(c > 200 && c <= 258, 1'b1)
    xfer(LEG, 1'b0, OFF_CSR_FIRST, 32'h0, q);
    `CHK(q[BIT_STATE], 1'b1)
    xfer(LEG, 1'b1, OFF_CSR_FIRST, 32'h5, q);
    `CHK(irq_l, 1'b0)
    wait_hi(irq_l, 400, c);
    wait_hi(rst_l, 400, c);
    `CHK(rst_l, 1'b1)
    xfer(LEG, 1'b0, OFF_CSR_FIRST, 32'h0, q);
    `CHK(q[BIT_RST_STAT], 1'b1)
    xfer(LEG, 1'b1, OFF_CSR_FIRST, 32'h0, q);
    xfer(LEG, 1'b1, OFF_CSR_SECOND, 32'h0, q);
    xfer(LEG, 1'b1, OFF_CSR_FIRST, 32'h1, q);
    `CHK(rst_l, 1'b1)
    do_reset();
    `CHK(rst_l, 1'b0)
    xfer(LEG, 1'b0, OFF_CSR_FIRST, 32'h0, q);
    `CHK(q[BIT_RST_STAT], 1'b1)
    // legacy: one disable write is not enough
    xfer(LEG, 1'b1, OFF_CSR_FIRST, 32'h9, q);
    xfer(LEG, 1'b1, OFF_CSR_SECOND, 32'h1, q);
    xfer(LEG, 1'b1, OFF_CSR_FIRST, 32'h0, q);
    wait_hi(irq_l, 400, c);
    `CHK(irq_l, 1'b1)
    xfer(LEG, 1'b1, OFF_CSR_SECOND, 32'h0, q);
    xfer(LEG, 1'b1, OFF_CSR_FIRST, 32'h4, q);
    repeat (300) @(posedge hclk);
    `CHK(irq_l, 1'b0)
    // legacy: freeze stalls the counter
    freeze <= 1'b1;
    xfer(LEG, 1'b1, OFF_CSR_FIRST, 32'h1, q);
    repeat (400) @(posedge hclk);
    `CHK(irq_l, 1'b0)
    freeze <= 1'b0;
    wait_hi(irq_l, 400, c);
    `CHK(irq_l, 1'b1)
    // windowed: default windows of 256 cycles each, fail counter and delay timer on
    do_reset();
    xfer(WIN, 1'b0, OFF_EN_STATUS, 32'h0, q);
    `CHK(q[10:8], FAIL_RESET)
    xfer(WIN, 1'b1, OFF_FUNC_CTRL, 32'h6, q);
    xfer(WIN, 1'b1, OFF_EN_STATUS, 32'h1, q);
    repeat (300) @(posedge hclk);
    xfer(WIN, 1'b1, OFF_EN_STATUS, 32'h3, q);
    xfer(WIN, 1'b1, OFF_EN_STATUS, 32'h3, q);
    xfer(WIN, 1'b1, OFF_EN_STATUS, 32'h0, q);
    xfer(WIN, 1'b0, OFF_EN_STATUS, 32'h0, q);
    `CHK(q[10:8], 3'h6)
    `CHK(q[BIT_ENABLE], 1'b1)
    `CHK(irq_w, 1'b1)
    repeat (500) @(posedge hclk);
    xfer(WIN, 1'b0, OFF_EN_STATUS, 32'h0, q);
    `CHK(q[10:8], FAIL_MAX)
    wait_hi(pend_w, 600, c);
    `CHK(pend_w, 1'b1)
    `CHK(rst_w, 1'b0)
    wait_hi(rst_w, 300, c);
    `CHK(rst_w, 1'b1)
    `CHK(c > 240, 1'b1)
    xfer(WIN, 1'b0, OFF_EN_STATUS, 32'h0, q);
    `CHK(q[BIT_ENABLE], 1'b0)
    `CHK(q[4], 1'b1)
    // windowed: signature mismatch without fail counter resets at once
    do_reset();
    xfer(WIN, 1'b1, OFF_FUNC_CTRL, 32'h1, q);
    xfer(WIN, 1'b1, OFF_SIG_INIT, 32'h0000_a5a5, q);
    xfer(WIN, 1'b1, OFF_SIG_RESULT, 32'h0000_a5a4, q);
    xfer(WIN, 1'b1, OFF_EN_STATUS, 32'h1, q);
    repeat (300) @(posedge hclk);
    xfer(WIN, 1'b1, OFF_EN_STATUS, 32'h3, q);
    wait_hi(rst_w, 40, c);
    `CHK(rst_w, 1'b1)
    conclude();
  end
endmodule // timebase_window_watchdog_test
